// ---- core/nvs_caller.sv ----
// nvs_caller: apb-driven caller that issues byte store calls
`timescale 1ns/1ps
module nvs_caller (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  nvs_if.cpu link
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    nvs_pkg::nvs_host_state_t st;
    logic [7:0] argAddr;
    logic [7:0] argData;
    logic [15:0] freq;
    logic [7:0] stackFree;
    logic call;
    logic [15:0] entry;
    logic busy;
    logic done;
    logic refused;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [31:0] prdata;
    logic pready;
  } nvs_caller_state_t;

  nvs_caller_state_t q_r;
  nvs_caller_state_t q_nxt;
  logic wrEn;

  // write lands on the access edge that sees pready
  assign wrEn = psel && penable && q_r.pready && pwrite;

  // ****************************************
  // register access and call control
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.call = 1'b0;
    // one wait-free access phase per transfer
    q_nxt.pready = psel && !penable && !q_r.pready;
    if (psel && !penable) begin
      case (paddr)
        nvs_pkg::REG_ARG: q_nxt.prdata = {16'h0000, q_r.argData, q_r.argAddr};
        nvs_pkg::REG_RESULT: q_nxt.prdata = {13'h0000, q_r.refused, q_r.done, q_r.busy, q_r.r1, q_r.r0};
        nvs_pkg::REG_FREQ: q_nxt.prdata = {16'h0000, q_r.freq};
        nvs_pkg::REG_STACK: q_nxt.prdata = {24'h000000, q_r.stackFree};
        default: q_nxt.prdata = 32'h00000000;
      endcase
    end
    // arguments cannot change under a running call
    if (wrEn && paddr == nvs_pkg::REG_ARG && !q_r.busy) begin
      q_nxt.argAddr = pwdata[7:0];
      q_nxt.argData = pwdata[15:8];
    end
    if (wrEn && paddr == nvs_pkg::REG_FREQ) begin
      q_nxt.freq = pwdata[15:0];
    end
    if (wrEn && paddr == nvs_pkg::REG_STACK) begin
      q_nxt.stackFree = pwdata[7:0];
    end
    case (q_r.st)
      nvs_pkg::HS_IDLE: begin
        if (wrEn && paddr == nvs_pkg::REG_CMD && (pwdata[nvs_pkg::CMD_WRITE_BIT] || pwdata[nvs_pkg::CMD_READ_BIT])) begin
          // no call before flash frequency set
          // no call without 15 free stack bytes
          if (q_r.freq == 16'h0000 || {24'h0, q_r.stackFree} < nvs_pkg::STACK_NEED) begin
            q_nxt.refused = 1'b1;
          end else begin
            // write call on bit0, wins over read; read call otherwise
            q_nxt.entry = pwdata[nvs_pkg::CMD_WRITE_BIT] ? nvs_pkg::ENTRY_WRITE : nvs_pkg::ENTRY_READ;
            q_nxt.call = 1'b1;
            q_nxt.busy = 1'b1;
            q_nxt.done = 1'b0;
            q_nxt.refused = 1'b0;
            q_nxt.st = nvs_pkg::HS_WAIT;
          end
        end
      end
      nvs_pkg::HS_WAIT: begin
        // arguments held until the answer; freq and stack registers stay writable
        // stall until the store reports done
        if (link.done) begin
          q_nxt.r0 = link.r0;
          q_nxt.r1 = (q_r.entry == nvs_pkg::ENTRY_READ) ? link.r1 : 8'h00;
          q_nxt.busy = 1'b0;
          q_nxt.done = 1'b1;
          q_nxt.st = nvs_pkg::HS_IDLE;
        end
      end
      default: q_nxt.st = nvs_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q_r <= '0;
      q_r.freq <= nvs_pkg::FREQ_RST;
      q_r.stackFree <= nvs_pkg::STACK_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = 1'b0;
  assign link.call = q_r.call;
  assign link.entry = q_r.entry;
  assign link.argAddr = q_r.argAddr;
  assign link.argData = q_r.argData;
  assign link.flashFreq = q_r.freq;
endmodule // nvs_caller

// ---- core/nvs_store.sv ----
// nvs_store: nonvolatile byte store with two-copy wear spreading and crc checks
`timescale 1ns/1ps
module nvs_store #(
  parameter int STORE_BYTES = nvs_pkg::STORE_BYTES,
  parameter int WRITE_CYC = nvs_pkg::WRITE_CYC,
  parameter int RECOPY_CYC = nvs_pkg::RECOPY_CYC,
  parameter int READ_MIN_CYC = nvs_pkg::READ_MIN_CYC,
  parameter int READ_MAX_CYC = nvs_pkg::READ_MAX_CYC,
  parameter int READ_STEP_CYC = nvs_pkg::READ_STEP_CYC,
  parameter int RECOPY_EVERY = nvs_pkg::RECOPY_EVERY
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic eraseAll,
  nvs_if.dev link
);
  // ****************************************
  // state
  // ****************************************
  localparam int SLOTS = 2 * nvs_pkg::STORE_BYTES;

  typedef struct packed {
    nvs_pkg::nvs_dev_state_t st;
    logic isWrite;
    logic legal;
    logic [7:0] addr;
    logic [7:0] data;
    logic slot;
    logic [21:0] waitCnt;
    logic [8:0] sinceRecopy;
    logic busy;
    logic done;
    logic [7:0] r0;
    logic [7:0] r1;
  } nvs_store_state_t;

  nvs_store_state_t q_r;
  nvs_store_state_t q_nxt;

  // nonvolatile part: no reset, survives system reset like flash does
  logic [23:0] mem [SLOTS];
  logic newest [nvs_pkg::STORE_BYTES];
  logic pending;
  logic pendingSet;
  logic pendingClr;
  logic memWe;
  logic [7:0] memIdx;
  logic [23:0] memVal;
  logic selWe;

  logic inRange;
  logic known;
  logic selBit;
  logic [23:0] eNew;
  logic [23:0] eOld;
  logic [23:0] eChk;
  logic recopyDue;
  int rdCyc;

  // only the first STORE_BYTES addresses exist
  assign inRange = (STORE_BYTES != 0) && ({24'h0, link.argAddr} < STORE_BYTES);
  assign known = (link.entry == nvs_pkg::ENTRY_WRITE) || (link.entry == nvs_pkg::ENTRY_READ);
  assign selBit = newest[link.argAddr[6:0]];
  assign eNew = mem[{link.argAddr[6:0], selBit}];
  assign eOld = mem[{link.argAddr[6:0], ~selBit}];
  assign eChk = mem[{q_r.addr[6:0], q_r.slot}];
  assign recopyDue = ({23'h0, q_r.sinceRecopy} + 32'd1) >= RECOPY_EVERY;

  // ****************************************
  // operation sequencer
  // ****************************************
  // every wait is a cycle count, so a slower clock stretches it in proportion
  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    memWe = 1'b0;
    memIdx = 8'h00;
    memVal = 24'h000000;
    selWe = 1'b0;
    pendingSet = 1'b0;
    pendingClr = 1'b0;
    // read time grows with writes since the last recopy, capped
    rdCyc = READ_MIN_CYC + int'(q_r.sinceRecopy) * READ_STEP_CYC;
    if (rdCyc > READ_MAX_CYC) begin
      rdCyc = READ_MAX_CYC;
    end
    case (q_r.st)
      nvs_pkg::DS_IDLE: begin
        if (link.call) begin
          q_nxt.isWrite = (link.entry == nvs_pkg::ENTRY_WRITE);
          // one address byte, one data byte
          q_nxt.addr = link.argAddr;
          q_nxt.data = link.argData;
          q_nxt.legal = inRange && known;
          q_nxt.busy = 1'b1;
          q_nxt.st = nvs_pkg::DS_BUSY;
          if (!(inRange && known)) begin
            // illegal write stores nothing, short wait
            q_nxt.waitCnt = 22'(nvs_pkg::ILLEGAL_CYC);
            q_nxt.r0 = (link.entry == nvs_pkg::ENTRY_WRITE) ? nvs_pkg::ILLEGAL_WR_STATUS : nvs_pkg::READ_BAD;
            q_nxt.r1 = nvs_pkg::READ_BAD;
          end else if (link.entry == nvs_pkg::ENTRY_WRITE) begin
            // alternate copy slot takes the new byte
            q_nxt.slot = ~selBit;
            memWe = 1'b1;
            memIdx = {link.argAddr[6:0], ~selBit};
            // slot marked damaged until commit; the older copy is untouched
            memVal = {link.argAddr, link.argData, ~nvs_pkg::nvs_crc8(link.argAddr, link.argData)};
            pendingSet = 1'b1;
            q_nxt.waitCnt = recopyDue ? 22'(RECOPY_CYC) : 22'(WRITE_CYC);
            q_nxt.sinceRecopy = recopyDue ? 9'h000 : q_r.sinceRecopy + 9'h001;
            q_nxt.r0 = 8'h00;
            q_nxt.r0[nvs_pkg::ST_RECOPY] = recopyDue;
            q_nxt.r0[nvs_pkg::ST_PWRFAIL] = pending;
            q_nxt.r1 = 8'h00;
          end else begin
            q_nxt.waitCnt = 22'(rdCyc);
            // status nonzero when a copy of this address is torn
            // fall back to older intact copy
            if (nvs_pkg::nvs_entry_ok(link.argAddr, eNew)) begin
              q_nxt.r0 = eNew[15:8];
              // a write cut by reset leaves its own tag with a broken crc in the other slot
              q_nxt.r1 = {7'h00, (eOld[23:16] == link.argAddr) && !nvs_pkg::nvs_entry_ok(link.argAddr, eOld)};
            end else if (nvs_pkg::nvs_entry_ok(link.argAddr, eOld)) begin
              q_nxt.r0 = eOld[15:8];
              q_nxt.r1 = 8'h01;
            end else begin
              q_nxt.r0 = nvs_pkg::READ_BAD;
              q_nxt.r1 = 8'h02;
            end
          end
        end
      end
      nvs_pkg::DS_BUSY: begin
        q_nxt.waitCnt = q_r.waitCnt - 22'h000001;
        if (q_r.waitCnt <= 22'h000001) begin
          q_nxt.st = nvs_pkg::DS_CHECK;
          if (q_r.isWrite && q_r.legal) begin
            // commit is one step; a reset before it leaves only this slot bad
            memWe = 1'b1;
            memIdx = {q_r.addr[6:0], q_r.slot};
            memVal = {q_r.addr, q_r.data, nvs_pkg::nvs_crc8(q_r.addr, q_r.data)};
            selWe = 1'b1;
            pendingClr = 1'b1;
          end
        end
      end
      nvs_pkg::DS_CHECK: begin
        if (q_r.isWrite && q_r.legal) begin
          q_nxt.r0[nvs_pkg::ST_ADDRERR] = (eChk[23:16] != q_r.addr);
          q_nxt.r0[nvs_pkg::ST_DATAERR] = (eChk[15:8] != q_r.data) || (eChk[7:0] != nvs_pkg::nvs_crc8(eChk[23:16], eChk[15:8]));
        end
        q_nxt.busy = 1'b0;
        q_nxt.done = 1'b1;
        q_nxt.st = nvs_pkg::DS_IDLE;
      end
      default: begin
        q_nxt.st = nvs_pkg::DS_IDLE;
        q_nxt.busy = 1'b0;
      end
    endcase
  end

  // control register, cleared by reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // flash image
  // ****************************************
  // no reset here on purpose: contents must outlive a system reset
  always_ff @(posedge clk) begin
    if (eraseAll) begin
      for (int i = 0; i < SLOTS; i++) begin
        mem[i] <= nvs_pkg::BLANK_ENTRY;
      end
      for (int j = 0; j < nvs_pkg::STORE_BYTES; j++) begin
        newest[j] <= 1'b0;
      end
      pending <= 1'b0;
    end else begin
      if (memWe) begin
        mem[memIdx] <= memVal;
      end
      if (selWe) begin
        newest[q_r.addr[6:0]] <= q_r.slot;
      end
      if (pendingSet) begin
        pending <= 1'b1;
      end else if (pendingClr) begin
        pending <= 1'b0;
      end
    end
  end

  // results stay until the next call is taken
  assign link.busy = q_r.busy;
  assign link.done = q_r.done;
  assign link.r0 = q_r.r0;
  assign link.r1 = q_r.r1;
endmodule // nvs_store

// ---- inc/nvs_if.sv ----
// nvs_if: call link between caller logic and the byte store
`timescale 1ns/1ps
interface nvs_if;
  logic call;
  logic [15:0] entry;
  logic [7:0] argAddr;
  logic [7:0] argData;
  logic [15:0] flashFreq;
  logic busy;
  logic done;
  logic [7:0] r0;
  logic [7:0] r1;
  modport dev (input call, input entry, input argAddr, input argData, input flashFreq,
               output busy, output done, output r0, output r1);
  modport cpu (output call, output entry, output argAddr, output argData, output flashFreq,
               input busy, input done, input r0, input r1);
endinterface

// ---- inc/nvs_pkg.sv ----
// nvs_pkg: shared constants, types and checks for the nonvolatile byte store
package nvs_pkg;
  // ****************************************
  // clock, size and call entry points
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int STORE_BYTES = 128;
  localparam int ADDR_W = 8;
  localparam logic [15:0] ENTRY_WRITE = 16'h10b3;
  localparam logic [15:0] ENTRY_READ = 16'h1000;
  localparam logic [7:0] READ_BAD = 8'hff;
  localparam logic [7:0] ILLEGAL_WR_STATUS = 8'h00;
  localparam logic [23:0] BLANK_ENTRY = 24'hffffff;
  // write status bit positions, bits 7..4 stay zero
  localparam int ST_RECOPY = 3;
  localparam int ST_PWRFAIL = 2;
  localparam int ST_ADDRERR = 1;
  localparam int ST_DATAERR = 0;

  // ****************************************
  // times as printed and derived cycle counts
  // ****************************************
  localparam longint WRITE_NS = 251000;
  localparam longint RECOPY_NS = 61000000;
  localparam longint READ_MIN_NS = 44000;
  localparam longint READ_MAX_NS = 489000;
  localparam longint ILLEGAL_NS = 2000;
  localparam longint READ_STEP_NS = 1000;
  localparam int WRITE_CYC = int'((WRITE_NS * CLK_MHZ + 999) / 1000);
  localparam int RECOPY_CYC = int'((RECOPY_NS * CLK_MHZ) / 1000);
  localparam int READ_MIN_CYC = int'((READ_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam int READ_MAX_CYC = int'((READ_MAX_NS * CLK_MHZ) / 1000);
  localparam int ILLEGAL_CYC = int'((ILLEGAL_NS * CLK_MHZ + 999) / 1000);
  localparam int READ_STEP_CYC = int'((READ_STEP_NS * CLK_MHZ + 999) / 1000);
  localparam int RECOPY_EVERY = 450;
  localparam int STACK_NEED = 15;

  // ****************************************
  // caller register map (apb word offsets)
  // ****************************************
  localparam logic [7:0] REG_ARG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_FREQ = 8'h0c;
  localparam logic [7:0] REG_STACK = 8'h10;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [7:0] STACK_RST = 8'h40;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int RES_BUSY = 16;
  localparam int RES_DONE = 17;
  localparam int RES_REFUSED = 18;

  typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_BUSY = 2'b01, DS_CHECK = 2'b11} nvs_dev_state_t;
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_WAIT = 2'b01} nvs_host_state_t;

  // crc over tag and data, polynomial x^8+x^2+x+1
  function automatic logic [7:0] nvs_crc8(input logic [7:0] tag, input logic [7:0] dat);
    logic [7:0] c;
    logic [15:0] s;
    c = 8'h00;
    s = {tag, dat};
    for (int i = 15; i >= 0; i--) begin
      c = c[7] ^ s[i] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // an entry {tag,data,crc} is intact when tag matches and crc holds
  function automatic logic nvs_entry_ok(input logic [7:0] addr, input logic [23:0] e);
    return (e[23:16] == addr) && (e[7:0] == nvs_crc8(e[23:16], e[15:8]));
  endfunction
endpackage

// ---- tb/nvs_link_monitor.sv ----
// nvs_link_monitor: timing and status checks on the store call link
`timescale 1ns/1ps
module nvs_link_monitor #(
  parameter int WRITE_CYC = 20,
  parameter int RECOPY_CYC = 60,
  parameter int READ_MIN_CYC = 5,
  parameter int READ_MAX_CYC = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic call,
  input wire logic [15:0] entry,
  input wire logic [7:0] argAddr,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] r0,
  input wire logic [7:0] r1
);
  // ****
  // link checks
  // ****
  // done lands wait count plus two edges after the taking edge
  localparam int WR_D = WRITE_CYC + 2;
  localparam int RC_D = RECOPY_CYC + 2;
  localparam int RD_LO = READ_MIN_CYC + 2;
  localparam int RD_HI = READ_MAX_CYC + 2;
  localparam int IL_D = nvs_pkg::ILLEGAL_CYC + 2;
  logic takeWr;
  logic takeRd;
  logic legal;

  // a call is only taken while the store is idle
  assign takeWr = call && !busy && (entry == nvs_pkg::ENTRY_WRITE);
  assign takeRd = call && !busy && (entry == nvs_pkg::ENTRY_READ);
  assign legal = argAddr < nvs_pkg::STORE_BYTES;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // latency of each kind of call; result of illegal calls and write status top bits
  wr_latency_a: assert property (takeWr && legal |-> (##WR_D done) or (##RC_D done))
    else $error("write done off time");
  ill_write_a: assert property (takeWr && !legal |-> ##IL_D (done && r0 == nvs_pkg::ILLEGAL_WR_STATUS))
    else $error("illegal write wrong");
  rd_latency_a: assert property (takeRd && legal |-> ##[RD_LO:RD_HI] done)
    else $error("read done off time");
  ill_read_a: assert property (takeRd && !legal |-> ##IL_D (done && r0 == nvs_pkg::READ_BAD))
    else $error("illegal read wrong");
  status_high_a: assert property (done && entry == nvs_pkg::ENTRY_WRITE |-> r0[7:4] == 4'h0)
    else $error("status top bits set");
  // busy brackets exactly one operation
  busy_start_a: assert property (call && !busy |=> busy)
    else $error("busy missing after call");
  busy_end_a: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  call_idle_a: assert property (call |-> !busy ##1 !call)
    else $error("call while busy or long");
  args_held_a: assert property (busy |-> $stable(argAddr))
    else $error("address moved while busy");
  entry_known_a: assert property (call |-> entry == nvs_pkg::ENTRY_WRITE || entry == nvs_pkg::ENTRY_READ)
    else $error("unknown entry called");
  result_held_a: assert property (!call && !busy |=> $stable(r0) && $stable(r1))
    else $error("result moved while idle");
endmodule // nvs_link_monitor

// ---- tb/testbench.sv ----
// testbench: caller and store joined by the call link, driven over apb
`timescale 1ns/1ps
module testbench;
  // ****
  // setup
  // ****
  // short counts keep the run small, recopy every fourth write
  localparam int WC = 20;
  localparam int RC = 60;
  localparam int RMIN = 5;
  localparam int RMAX = 40;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic eraseAll = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic [31:0] res;
  int mismatches = 0;
  int samples_checked = 0;

  nvs_if linkBus();
  nvs_store #(.WRITE_CYC(WC), .RECOPY_CYC(RC), .READ_MIN_CYC(RMIN), .READ_MAX_CYC(RMAX),
    .READ_STEP_CYC(1), .RECOPY_EVERY(4)) nvs_store_i (.clk(clk), .reset(reset), .eraseAll(eraseAll),
    .link(linkBus));
  nvs_caller nvs_caller_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .link(linkBus));
  nvs_link_monitor #(.WRITE_CYC(WC), .RECOPY_CYC(RC), .READ_MIN_CYC(RMIN), .READ_MAX_CYC(RMAX))
    nvs_link_monitor_i (.clk(clk), .reset(reset), .call(linkBus.call), .entry(linkBus.entry),
    .argAddr(linkBus.argAddr), .busy(linkBus.busy), .done(linkBus.done), .r0(linkBus.r0), .r1(linkBus.r1));

  always #12.5 clk = ~clk;

  // ****
  // shared tasks
  // ****
  task automatic tally_and_finish();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // a hung wait counts as a mismatch and closes the run
  task automatic give_up();
    mismatches++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  // one apb transfer, entered just after an edge; an idle cycle follows
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up();
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // load arguments, issue the call, poll until the result is done
  task automatic op(input logic [1:0] cmd, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    xfer(1'b1, nvs_pkg::REG_ARG, {16'h0000, d, a}, q);
    xfer(1'b1, nvs_pkg::REG_CMD, {30'h0, cmd}, q);
    do begin
      xfer(1'b0, nvs_pkg::REG_RESULT, 32'h0, q);
      n++;
    end while (!(q[nvs_pkg::RES_DONE] === 1'b1 && q[nvs_pkg::RES_BUSY] === 1'b0) && n < 100);
    if (q[nvs_pkg::RES_DONE] !== 1'b1) give_up();
  endtask

  // ****
  // scenarios
  // ****
  // reset values, unmapped place, refusal without frequency or stack
  task automatic t_regs();
    xfer(1'b0, 8'h14, 32'h0, res);
    chk(res, 32'h0);
    xfer(1'b0, nvs_pkg::REG_STACK, 32'h0, res);
    chk(res, {24'h0, nvs_pkg::STACK_RST});
    xfer(1'b1, nvs_pkg::REG_CMD, 32'h1, res);
    xfer(1'b0, nvs_pkg::REG_RESULT, 32'h0, res);
    chk({31'h0, res[nvs_pkg::RES_REFUSED]}, 32'h1);
    xfer(1'b1, nvs_pkg::REG_FREQ, 32'd40, res);
    xfer(1'b1, nvs_pkg::REG_STACK, 32'd14, res);
    xfer(1'b1, nvs_pkg::REG_CMD, 32'h1, res);
    xfer(1'b0, nvs_pkg::REG_RESULT, 32'h0, res);
    chk({31'h0, res[nvs_pkg::RES_REFUSED]}, 32'h1);
    xfer(1'b1, nvs_pkg::REG_STACK, 32'd15, res);
  endtask

  // boundary addresses, recopy on the fourth write, read back, blank slot
  task automatic t_store();
    logic [7:0] ad [4] = '{8'h05, 8'h7f, 8'h00, 8'h05};
    logic [7:0] dt [4] = '{8'ha5, 8'h5a, 8'h01, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      op(2'b01, ad[i], dt[i], res);
      chk({16'h0, res[15:0]}, (i == 3) ? 32'h8 : 32'h0);
    end
    for (int i = 1; i < 4; i++) begin
      op(2'b10, ad[i], 8'h00, res);
      chk({16'h0, res[15:0]}, {24'h0, dt[i]});
    end
    op(2'b10, 8'h20, 8'h00, res);
    chk({16'h0, res[15:0]}, 32'h02ff);
    // both command bits set: only the write is called, no read follows
    op(2'b11, 8'h00, 8'h02, res);
    chk({16'h0, res[15:0]}, 32'h0);
    op(2'b10, 8'h00, 8'h00, res);
    chk({16'h0, res[15:0]}, 32'h0002);
  endtask

  // reset in mid write: flag on next write, older copy returned, others intact
  task automatic t_reset();
    xfer(1'b1, nvs_pkg::REG_ARG, {16'h0, 8'h3c, 8'h05}, res);
    xfer(1'b1, nvs_pkg::REG_CMD, 32'h1, res);
    repeat (6) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    xfer(1'b0, nvs_pkg::REG_FREQ, 32'h0, res);
    chk(res, {16'h0, nvs_pkg::FREQ_RST});
    xfer(1'b1, nvs_pkg::REG_FREQ, 32'd40, res);
    op(2'b01, 8'h10, 8'h77, res);
    chk({16'h0, res[15:0]}, 32'h4);
    op(2'b10, 8'h05, 8'h00, res);
    chk({16'h0, res[15:0]}, 32'h01c3);
    op(2'b10, 8'h7f, 8'h00, res);
    chk({16'h0, res[15:0]}, 32'h005a);
    op(2'b10, 8'h10, 8'h00, res);
    chk({16'h0, res[15:0]}, 32'h0077);
  endtask

  // out-of-range write changes nothing (0x80 would alias to 0x00), out-of-range read gives ff
  task automatic t_illegal();
    op(2'b01, 8'h80, 8'h99, res);
    chk({16'h0, res[15:0]}, {24'h0, nvs_pkg::ILLEGAL_WR_STATUS});
    op(2'b10, 8'hff, 8'h00, res);
    chk({24'h0, res[7:0]}, {24'h0, nvs_pkg::READ_BAD});
    op(2'b10, 8'h00, 8'h00, res);
    chk({16'h0, res[15:0]}, 32'h0002);
  endtask

  // reset, then blank the array once before any call
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    eraseAll <= 1'b0;
    @(posedge clk);
    t_regs();
    t_store();
    t_reset();
    t_illegal();
    tally_and_finish();
  end
endmodule // testbench
